// >>> core/fpd_post_divider.sv
/*
 * Output D post-divider: divided clock (high one cycle longer for odd ratios) or frame pulse, one APB register.
 * Assumes the related clocks A, B and C come from sibling dividers on clk_in.
 */
`timescale 1ns/1ns
`default_nettype none
module fpd_post_divider
    import fpd_pkg::*;
(
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    input  wire logic          en_in,
    input  wire fpd_apb_req_t  apb_in,
    output logic               pready_out,
    output logic [31:0]        prdata_out,
    output logic               pslverr_out,
    input  wire logic [2:0]    rel_clk_in,
    output logic               div_out
);

    fpd_state_t  st_r;
    fpd_state_t  st_nxt;
    fpd_cfg_t    cfg;
    fpd_cfg_t    new_cfg;
    logic        frame;
    logic        rel;
    logic        rise;
    logic        fall;
    logic        upd_edge;
    logic        wrap;
    logic        bnd;
    logic        apply;
    logic        hit;
    logic [23:0] half;
    logic [23:0] high_len;
    logic [23:0] space_last;

    always_comb begin
        st_nxt     = st_r;
        cfg        = fpd_cfg_t'(st_r.act);
        new_cfg    = fpd_cfg_t'(st_r.act);
        frame      = (cfg.mode == FPD_MODE_FRAME);
        rel        = (cfg.rel_sel == FPD_SEL_RSVD) ? 1'b0 : rel_clk_in[cfg.rel_sel];
        rise       = rel & ~st_r.rel_prev;
        fall       = ~rel & st_r.rel_prev;
        upd_edge   = cfg.edge_type ? rise : fall;
        space_last = (cfg.spacing == 16'h0000) ? 24'h000000 : {8'h00, cfg.spacing - 16'h0001};
        wrap       = 1'b0;
        bnd        = 1'b0;
        hit        = (apb_in.paddr == FPD_REG_ADDR);
        half       = 24'h000000;
        high_len   = 24'h000000;
        st_nxt.rel_prev = rel;
        if (frame) begin
            if (rise) begin
                if (st_r.cnt >= space_last) begin
                    st_nxt.cnt = 24'h000000;
                    wrap       = 1'b1;
                end else begin
                    st_nxt.cnt = st_r.cnt + 24'h000001;
                end
            end
            if (cfg.edge_type) begin
                if (rise) begin
                    st_nxt.pulse = wrap;
                end
            end else if (fall) begin
                st_nxt.pulse = (st_r.cnt == space_last);
            end
            // Switch where the pulse is idle, or on any update edge at spacing 0 or 1, so no half pulse escapes
            bnd = (cfg.rel_sel == FPD_SEL_RSVD) | (upd_edge & (~st_nxt.pulse | (space_last == 24'h000000)));
        end else if (st_r.act < FPD_MIN_RATIO) begin
            bnd = 1'b1;
        end else if (st_r.cnt == st_r.act - 24'h000001) begin
            st_nxt.cnt = 24'h000000;
            bnd        = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 24'h000001;
        end
        apply = bnd & st_r.pend;
        if (apply) begin
            st_nxt.act   = st_r.cfg_reg;
            st_nxt.pend  = 1'b0;
            st_nxt.cnt   = 24'h000000;
            st_nxt.pulse = 1'b0;
        end
        new_cfg = fpd_cfg_t'(st_nxt.act);
        half     = st_nxt.act >> 1;
        high_len = st_nxt.act - half;
        if (new_cfg.mode == FPD_MODE_FRAME) begin
            st_nxt.level = st_nxt.pulse ^ new_cfg.polarity;
        end else begin
            // Odd ratios put the extra cycle in the high half
            st_nxt.level = (st_nxt.act >= FPD_MIN_RATIO) && (st_nxt.cnt < high_len);
        end
        if (apb_in.psel && !apb_in.penable && !apb_in.pwrite) begin
            st_nxt.rdata = hit ? {8'h00, st_r.cfg_reg} : 32'h00000000;
        end
        // A write in the apply cycle keeps pending set, so it is not lost
        if (apb_in.psel && apb_in.penable && apb_in.pwrite && hit) begin
            st_nxt.cfg_reg = apb_in.pwdata[23:0];
            st_nxt.pend    = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r         <= '0;
            st_r.cfg_reg <= FPD_REG_RESET;
            st_r.act     <= FPD_REG_RESET;
        end else if (en_in) begin
            st_r <= st_nxt;
        end
    end

    assign pready_out  = 1'b1;
    assign pslverr_out = apb_in.psel & apb_in.penable & ~hit;
    assign prdata_out  = st_r.rdata;
    assign div_out     = st_r.level;

    // Checking helpers
    logic [23:0] hi_len_r;
    logic [23:0] lo_len_r;
    logic        chk_steady_r;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hi_len_r     <= 24'h000000;
            lo_len_r     <= 24'h000000;
            chk_steady_r <= 1'b0;
        end else if (en_in) begin
            hi_len_r     <= (apply || !st_nxt.level) ? {23'h0, st_nxt.level} : hi_len_r + 24'h000001;
            lo_len_r     <= (apply || st_nxt.level) ? {23'h0, !st_nxt.level} : lo_len_r + 24'h000001;
            chk_steady_r <= apply ? 1'b0 : (chk_steady_r | (st_nxt.level != st_r.level));
        end
    end

    property p_frame_reserved_idle;
        @(posedge clk_in) disable iff (rst_in)
        (frame && cfg.rel_sel == FPD_SEL_RSVD) |-> (div_out == cfg.polarity && !st_r.pulse);
    endproperty
    a_frame_reserved_idle: assert property (p_frame_reserved_idle) else $error("Reserved select produced a pulse");

    property p_normal_high_len;
        @(posedge clk_in) disable iff (rst_in)
        ($past(en_in) && !frame && $stable(st_r.act) && chk_steady_r && $fell(div_out))
            |-> ($past(hi_len_r) == st_r.act - (st_r.act >> 1));
    endproperty
    a_normal_high_len: assert property (p_normal_high_len) else $error("Normal clock high time wrong");

    property p_normal_low_len;
        @(posedge clk_in) disable iff (rst_in)
        ($past(en_in) && !frame && $stable(st_r.act) && chk_steady_r && $rose(div_out))
            |-> ($past(lo_len_r) == (st_r.act >> 1));
    endproperty
    a_normal_low_len: assert property (p_normal_low_len) else $error("Normal clock low time wrong");

    property p_spacing_bound;
        @(posedge clk_in) disable iff (rst_in)
        frame |-> (st_r.cnt <= space_last);
    endproperty
    a_spacing_bound: assert property (p_spacing_bound) else $error("Frame counter passed spacing");

    property p_pulse_one_period;
        @(posedge clk_in) disable iff (rst_in)
        (en_in && frame && upd_edge && st_r.pulse && space_last != 24'h000000 && !st_r.pend) |=> !st_r.pulse;
    endproperty
    a_pulse_one_period: assert property (p_pulse_one_period) else $error("Pulse longer than one period");

    property p_polarity;
        @(posedge clk_in) disable iff (rst_in)
        (frame && $stable(st_r.act) && $rose(st_r.pulse)) |-> (div_out == !cfg.polarity);
    endproperty
    a_polarity: assert property (p_polarity) else $error("Pulse polarity wrong");

    property p_pulse_edge_type;
        @(posedge clk_in) disable iff (rst_in)
        (frame && $stable(st_r.act) && $changed(st_r.pulse))
            |-> (cfg.edge_type ? ($past(rel) && !$past(st_r.rel_prev)) : (!$past(rel) && $past(st_r.rel_prev)));
    endproperty
    a_pulse_edge_type: assert property (p_pulse_edge_type) else $error("Pulse moved on wrong edge");

    property p_apply_at_boundary;
        @(posedge clk_in) disable iff (rst_in)
        $changed(st_r.act) |-> ($past(apply) && $past(en_in) && st_r.cnt == 24'h000000);
    endproperty
    a_apply_at_boundary: assert property (p_apply_at_boundary) else $error("Setting applied mid period");

    property p_ratio_low_idle;
        @(posedge clk_in) disable iff (rst_in)
        (!frame && st_r.act < FPD_MIN_RATIO) |-> !div_out;
    endproperty
    a_ratio_low_idle: assert property (p_ratio_low_idle) else $error("Ratio below two drove the output");

    property p_normal_count_bound;
        @(posedge clk_in) disable iff (rst_in)
        (!frame && st_r.act >= FPD_MIN_RATIO) |-> (st_r.cnt < st_r.act);
    endproperty
    a_normal_count_bound: assert property (p_normal_count_bound) else $error("Divider counter passed ratio");

    property p_normal_no_pulse;
        @(posedge clk_in) disable iff (rst_in)
        !frame |-> !st_r.pulse;
    endproperty
    a_normal_no_pulse: assert property (p_normal_no_pulse) else $error("Pulse state left on in clock mode");

    property p_write_pending;
        @(posedge clk_in) disable iff (rst_in)
        (en_in && apb_in.psel && apb_in.penable && apb_in.pwrite && hit)
            |=> (st_r.pend && st_r.cfg_reg == $past(apb_in.pwdata[23:0]));
    endproperty
    a_write_pending: assert property (p_write_pending) else $error("Written value not held pending");

    // Reserved select has no related edges, so waiting for one would stall forever
    property p_reserved_applies_at_once;
        @(posedge clk_in) disable iff (rst_in)
        (en_in && frame && cfg.rel_sel == FPD_SEL_RSVD && st_r.pend) |=> (st_r.act == $past(st_r.cfg_reg));
    endproperty
    a_reserved_applies_at_once: assert property (p_reserved_applies_at_once) else $error("Reserved select delayed apply");

endmodule : fpd_post_divider
`default_nettype wire

// >>> core/fpd_pkg.sv
/*
 * Constants, field layout and carrier types for the frame pulse post-divider.
 * Assumes a single clock domain fed by the synthesizer VCO clock.
 */
package fpd_pkg;

    localparam logic [11:0] FPD_REG_INDEX   = 12'h0A1;
    localparam logic [11:0] FPD_REG_ADDR    = {FPD_REG_INDEX[9:0], 2'b00};
    localparam logic [23:0] FPD_REG_RESET   = 24'h000000;
    localparam logic [23:0] FPD_MAX_RATIO   = 24'hEFFFFF;
    localparam logic [3:0]  FPD_MODE_FRAME  = 4'hF;
    localparam logic [1:0]  FPD_SEL_A       = 2'h0;
    localparam logic [1:0]  FPD_SEL_B       = 2'h1;
    localparam logic [1:0]  FPD_SEL_C       = 2'h2;
    localparam logic [1:0]  FPD_SEL_RSVD    = 2'h3;
    localparam logic [23:0] FPD_MIN_RATIO   = 24'h000002;

    // Field positions: mode 23:20, type 19, polarity 18, select 17:16, spacing 15:0
    typedef struct packed {
        logic [3:0]  mode;
        logic        edge_type;
        logic        polarity;
        logic [1:0]  rel_sel;
        logic [15:0] spacing;
    } fpd_cfg_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } fpd_apb_req_t;

    typedef struct packed {
        logic [23:0] cfg_reg;
        logic [23:0] act;
        logic        pend;
        logic [23:0] cnt;
        logic        rel_prev;
        logic        pulse;
        logic        level;
        logic [31:0] rdata;
    } fpd_state_t;

endpackage : fpd_pkg

// >>> verification/fpd_downstream_model.sv
/* Far side of the post-divider: free sibling clocks and a run-length meter on the output.
   Assumes it shares clk_in with the divider. */
`timescale 1ns/1ns
`default_nettype none
module fpd_downstream_model (
    input  wire logic       clk_in,
    input  wire logic       div_in,
    output logic [2:0]      rel_clk_out,
    output int              hi_len_out,
    output int              lo_len_out,
    output int              run_out
);
    int   tick = 0;
    logic prev = 1'b0;
    initial rel_clk_out = 3'h0;
    initial hi_len_out = 0;
    initial lo_len_out = 0;
    initial run_out = 0;
    // Only siblings A, B, C exist here, so the divider can never pick itself
    always @(posedge clk_in) begin
        tick <= tick + 1;
        rel_clk_out <= {(tick % 8) < 4, (tick % 6) < 3, (tick % 4) < 2};
        prev <= div_in;
        if (div_in !== prev) begin
            run_out <= 1;
            if (prev) hi_len_out <= run_out;
            else lo_len_out <= run_out;
        end else begin
            run_out <= run_out + 1;
        end
    end
endmodule : fpd_downstream_model
`default_nettype wire

// >>> verification/frame_pulse_post_divider_bench.sv
/* Bench for the post-divider: register access over APB, then divided and frame pulse shapes.
   Assumes sibling clocks of 4, 6 and 8 cycles from the downstream model. */
`timescale 1ns/1ns
`default_nettype none
module frame_pulse_post_divider_bench;
    import fpd_pkg::*;
    logic         clk_in = 1'b0;
    logic         rst_in = 1'b1;
    logic         en_in  = 1'b1;
    fpd_apb_req_t apb_in = '0;
    logic         pready_out, pslverr_out, div_out, err;
    logic [31:0]  prdata_out, rd;
    logic [2:0]   rel_clk;
    int           hi_len, lo_len, run_len;
    int           mismatches = 0;
    int           total_checks = 0;
    always #25 clk_in = ~clk_in;
    fpd_post_divider i_dut (.clk_in(clk_in), .rst_in(rst_in), .en_in(en_in), .apb_in(apb_in),
        .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
        .rel_clk_in(rel_clk), .div_out(div_out));
    fpd_downstream_model i_far (.clk_in(clk_in), .div_in(div_out), .rel_clk_out(rel_clk),
        .hi_len_out(hi_len), .lo_len_out(lo_len), .run_out(run_len));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in) apb_in <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk_in) apb_in.penable <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        apb_in <= '0;
    endtask : apb
    // Long wait so that the pending value has reached a boundary and whole periods follow
    task automatic shape(input string what, input logic [23:0] val, input int hi, input int lo);
        apb(1'b1, FPD_REG_ADDR, {8'h00, val});
        repeat (120) @(posedge clk_in);
        chk({what, " high"}, 32'(hi), 32'(hi_len));
        chk({what, " low"}, 32'(lo), 32'(lo_len));
        $display("Test %s done", what);
    endtask : shape
    task automatic summarize;
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    initial begin
        repeat (5000) @(posedge clk_in);
        mismatches++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        apb(1'b0, FPD_REG_ADDR, 32'h0);
        chk("reset value", {8'h00, FPD_REG_RESET}, rd);
        // Reserved select applies at once, so no long count is left running
        apb(1'b1, FPD_REG_ADDR, 32'hAAF3_0005);
        apb(1'b0, FPD_REG_ADDR, 32'h0);
        chk("readback", 32'h00F3_0005, rd);
        chk("mapped err", 32'h0, {31'h0, err});
        en_in <= 1'b0;
        apb(1'b1, FPD_REG_ADDR, 32'h5);
        en_in <= 1'b1;
        apb(1'b1, 12'h288, 32'h5);
        chk("unmapped write err", 32'h1, {31'h0, err});
        apb(1'b0, 12'h288, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(1'b0, FPD_REG_ADDR, 32'h0);
        chk("frozen write", 32'h00F3_0005, rd);
        chk("ready", 32'h1, {31'h0, pready_out});
        $display("Test register done");
        shape("ratio 7", 24'h000007, 4, 3);
        shape("ratio 4", 24'h000004, 2, 2);
        shape("frame A edge", 24'hF80003, 4, 8);
        shape("frame B inverted", 24'hFD0003, 12, 6);
        shape("frame C centred", 24'hF20004, 8, 24);
        apb(1'b1, FPD_REG_ADDR, 32'h00F7_0001);
        repeat (120) @(posedge clk_in);
        chk("reserved level", 32'h1, {31'h0, div_out});
        chk("reserved still", 32'h1, {31'h0, run_len >= 60});
        apb(1'b1, FPD_REG_ADDR, {8'h00, FPD_MAX_RATIO});
        apb(1'b0, FPD_REG_ADDR, 32'h0);
        chk("max ratio", {8'h00, FPD_MAX_RATIO}, rd);
        $display("Test select done");
        summarize();
    end
endmodule : frame_pulse_post_divider_bench
`default_nettype wire
